// ### bench/art_timer_test.sv
// Self-checking bench for the PWM auto-reload timer: APB register tasks and directed tests.
// Assumes zero-wait APB slave with read data latched at setup; the bench drives all pins.
`timescale 1ns/100ps
module art_timer_test;
    logic clk, rstn, psel, penable, pwrite, haltMode, externalTimerClock, slvErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic pready, pslverr, overflowIrq, wakeUp, lastPin;
    logic [1:0] captureInPin, captureIrq;
    logic [3:0] pulseOutPin, pulseOutEnable;
    wire logic [7:0] evt = {wakeUp, overflowIrq, captureIrq, pulseOutPin};
    int miscompares, totalChecks, len, c0;

    art_timer i_art_timer (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .haltMode(haltMode), .externalTimerClock(externalTimerClock),
        .captureInPin(captureInPin), .pulseOutPin(pulseOutPin),
        .pulseOutEnable(pulseOutEnable), .overflowIrq(overflowIrq),
        .captureIrq(captureIrq), .wakeUp(wakeUp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            miscompares++;
            test_done();
        end
        rdData = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apbWrite(input logic [7:0] addr, input logic [7:0] data);
        apbXfer(1'b1, addr, data);
    endtask

    task automatic apbRead(input logic [7:0] addr, input logic [31:0] mask,
                           input logic [31:0] exp);
        apbXfer(1'b0, addr, 8'h00);
        check(rdData & mask, exp);
    endtask

    task automatic waitEvt(input int idx, input logic val);
        int n;
        for (n = 0; n < 600 && evt[idx] !== val; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 600) begin
            miscompares++;
            test_done();
        end
    endtask

    // Length in cycles of the next complete stretch of val on one event line
    task automatic measure(input int idx, input logic val);
        waitEvt(idx, !val);
        waitEvt(idx, val);
        for (len = 0; len < 600 && evt[idx] === val; len++) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic extPulses(input int count);
        repeat (count) begin
            @(posedge clk) externalTimerClock <= 1'b1;
            repeat (4) @(posedge clk);
            externalTimerClock <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, haltMode, externalTimerClock} = 5'b00000;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        captureInPin = 2'b10;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 8'h28; a += 4) apbRead(a[7:0], 32'hffffffff, 32'h0);
        for (int a = 0; a <= 8'h1c; a += 4) begin
            if (a != 8'h14 && a != 8'h18) apbWrite(a[7:0], 8'ha5 ^ a[7:0]);
            if (a != 8'h14 && a != 8'h18) apbRead(a[7:0], 32'hffffffff, 8'ha5 ^ a[7:0]);
        end
        apbWrite(art_pkg::OFF_PWMCTL, 8'h00);
        apbWrite(art_pkg::OFF_CAPCSR, 8'hff);
        apbRead(art_pkg::OFF_CAPCSR, 32'hffffffff, 32'h3c);
        apbWrite(art_pkg::OFF_CSR, 8'h74);
        apbRead(art_pkg::OFF_CSR, 32'hffffffff, 32'h70);
        apbRead(8'h2c, 32'hffffffff, 32'h0);
        check(slvErr, 1'b1);
        apbRead(8'h02, 32'h0, 32'h0);
        check(slvErr, 1'b1);
        $display("test registers done");

        apbWrite(art_pkg::OFF_RELOAD, 8'h00);
        apbWrite(art_pkg::OFF_CAR, 8'hfc);
        apbWrite(art_pkg::OFF_CSR, 8'h0a);
        waitEvt(6, 1'b1);
        apbRead(art_pkg::OFF_CSR, 32'hffffffff, 32'h0b);
        apbRead(art_pkg::OFF_CSR, 32'hffffffff, 32'h0a);
        check(overflowIrq, 1'b0);
        for (int n = 0; n < 8; n++) begin
            apbWrite(art_pkg::OFF_CSR, 8'h08 | (n << 4));
            apbWrite(art_pkg::OFF_CAR, 8'h00);
            apbRead(art_pkg::OFF_CAR, 32'h0, 32'h0);
            c0 = rdData;
            repeat ((8 << n) - 3) @(posedge clk);
            apbRead(art_pkg::OFF_CAR, 32'hff, (c0 + 8) & 8'hff);
        end
        apbWrite(art_pkg::OFF_CSR, 8'h00);
        apbRead(art_pkg::OFF_CAR, 32'h0, 32'h0);
        c0 = rdData;
        repeat (20) @(posedge clk);
        apbRead(art_pkg::OFF_CAR, 32'hff, c0);
        apbWrite(art_pkg::OFF_RELOAD, 8'h40);
        apbWrite(art_pkg::OFF_CSR, 8'h7c);
        apbRead(art_pkg::OFF_CAR, 32'hff, 32'h40);
        apbWrite(art_pkg::OFF_CAR, 8'h10);
        apbRead(art_pkg::OFF_CAR, 32'hff, 32'h10);
        $display("test counter done");

        apbWrite(art_pkg::OFF_RELOAD, 8'h00);
        apbWrite(art_pkg::OFF_DUTY0, 8'h80);
        apbWrite(art_pkg::OFF_PWMCTL, 8'h10);
        apbWrite(art_pkg::OFF_CSR, 8'h08);
        check(pulseOutEnable, 4'h1);
        measure(0, 1'b1);
        measure(0, 1'b1);
        check(len, 129);
        measure(0, 1'b0);
        check(len, 127);
        apbWrite(art_pkg::OFF_CSR, 8'h00);
        #1 lastPin = pulseOutPin[0];
        apbWrite(art_pkg::OFF_PWMCTL, 8'h11);
        #1 check(pulseOutPin, {3'b000, ~lastPin});
        $display("test pwm done");

        apbWrite(art_pkg::OFF_CAR, 8'h55);
        apbWrite(art_pkg::OFF_CAPCSR, 8'h1c);
        @(posedge clk) captureInPin <= 2'b11;
        waitEvt(4, 1'b1);
        check(captureIrq, 2'b01);
        apbRead(art_pkg::OFF_CAPCSR, 32'hffffffff, 32'h1d);
        apbWrite(art_pkg::OFF_CAR, 8'h66);
        @(posedge clk) captureInPin <= 2'b10;
        repeat (6) @(posedge clk);
        captureInPin <= 2'b11;
        repeat (8) @(posedge clk);
        apbRead(art_pkg::OFF_CAP1, 32'hffffffff, 32'h55);
        apbRead(art_pkg::OFF_CAPCSR, 32'hffffffff, 32'h1c);
        #1 check(captureIrq, 2'b00);
        @(posedge clk) captureInPin <= 2'b01;
        waitEvt(5, 1'b1);
        @(posedge clk) haltMode <= 1'b1;
        waitEvt(7, 1'b1);
        apbRead(art_pkg::OFF_CAP2, 32'hffffffff, 32'h66);
        haltMode <= 1'b0;
        $display("test capture done");

        apbWrite(art_pkg::OFF_RELOAD, 8'hfe);
        apbWrite(art_pkg::OFF_CAR, 8'hfd);
        apbWrite(art_pkg::OFF_CSR, 8'h8a);
        apbRead(art_pkg::OFF_CSR, 32'hffffffff, 32'h8b);
        haltMode <= 1'b1;
        apbWrite(art_pkg::OFF_RELOAD, 8'h10);
        apbRead(art_pkg::OFF_RELOAD, 32'hffffffff, 32'hfe);
        repeat (20) @(posedge clk);
        apbRead(art_pkg::OFF_CAR, 32'hffffffff, 32'hfd);
        extPulses(3);
        waitEvt(6, 1'b1);
        check(wakeUp, 1'b1);
        apbRead(art_pkg::OFF_CAR, 32'hffffffff, 32'hfe);
        @(posedge clk) haltMode <= 1'b0;
        apbRead(art_pkg::OFF_CSR, 32'hffffffff, 32'h8b);
        $display("test halt done");
        test_done();
    end
endmodule // art_timer_test

// ### logic/art_pkg.sv
// Package for the PWM auto-reload timer with capture.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
package art_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_DUTY3 = 8'h00;
    localparam logic [7:0] OFF_DUTY2 = 8'h04;
    localparam logic [7:0] OFF_DUTY1 = 8'h08;
    localparam logic [7:0] OFF_DUTY0 = 8'h0c;
    localparam logic [7:0] OFF_PWMCTL = 8'h10;
    localparam logic [7:0] OFF_CSR = 8'h14;
    localparam logic [7:0] OFF_CAR = 8'h18;
    localparam logic [7:0] OFF_RELOAD = 8'h1c;
    localparam logic [7:0] OFF_CAPCSR = 8'h20;
    localparam logic [7:0] OFF_CAP1 = 8'h24;
    localparam logic [7:0] OFF_CAP2 = 8'h28;
    // Timer control/status fields
    localparam int CSR_EXTCLK = 7;
    localparam int CSR_PRE_HI = 6;
    localparam int CSR_PRE_LO = 4;
    localparam int CSR_RUN = 3;
    localparam int CSR_FORCE = 2;
    localparam int CSR_OVIE = 1;
    localparam int CSR_OVF = 0;
    // Capture control/status fields
    localparam int CAP_EDGE_LO = 4;
    localparam int CAP_IE_LO = 2;
    localparam int CAP_FLAG_LO = 0;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam int PRESCALE_BITS = 7;

    typedef struct packed {
        logic extClk;
        logic [2:0] preSel;
        logic run;
        logic ovIe;
    } art_ctrl_t;

    typedef struct packed {
        logic [1:0] edgeRise;
        logic [1:0] irqEn;
    } art_capctl_t;
endpackage

// ### logic/art_timer.sv
// PWM auto-reload timer with four PWM outputs and two input captures.
// Assumes an APB master on clk; pins are asynchronous and synchronised here.
// Operation
// - In HALT with external clock, control registers freeze; counter runs, overflow wakes.
// - Each capture channel sets its own flag and interrupt independently.
// - Active capture edge copies the counter into the channel capture register.
// - Further captures blocked until software reads the capture register.
// - Capture interrupt asserted while flag and enable both set.
// - Capture inputs act as edge interrupts and wake from HALT when enabled.
// - Control bit 7 selects CPU clock or external clock for prescaler.
// - Bits 6:4 set prescale division two to the field value.
// - Bit 3 runs counter; clear freezes prescaler and counter.
// - Force-reload bit is write-only and reads zero.
// - Force reload loads reload value and clears prescaler.
// - Bit 1 enables overflow interrupt requested while flag set.
// - Overflow flag set on FFh wrap; cleared by reading control/status.
// - Counter access register reads and writes the live counter.
// - Overflow loads reload value and sets PWM levels high same cycle.
// - PWM control bits 7:4 enable each channel onto its pin.
// - Polarity 0: high while counter at or below compare; 1 inverts.
// - Changing polarity inverts the output immediately.
// - Duty register sets second edge; reload value sets common first edge.
// - Capture edge bits 5:4 select falling or rising; bits 7:6 read zero.
// - Capture control bits 3:2 enable channel 2 and 1 interrupts.
// - Capture flags set on capture, cleared by reading capture register.
// - Compare shadows load from duty registers only at overflow.
// - Overflow reload leaves the prescaler unchanged.
// - Counter write or forced reload clears the prescaler.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module art_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic haltMode,
    input wire logic externalTimerClock,
    input wire logic [1:0] captureInPin,
    output logic [3:0] pulseOutPin,
    output logic [3:0] pulseOutEnable,
    output logic overflowIrq,
    output logic [1:0] captureIrq,
    output logic wakeUp
);
    art_pkg::art_ctrl_t ctrl_r;
    art_pkg::art_capctl_t capCtl_r;
    logic [7:0] counter_r;
    logic [7:0] reload_r;
    logic [6:0] prescale_r;
    logic [3:0] outEnable_r;
    logic [3:0] polarity_r;
    logic [7:0] duty_r [4];
    logic [7:0] shadow_r [4];
    logic [3:0] pwmLevel_r;
    logic overflowFlag_r;
    logic [1:0] capFlag_r;
    logic [7:0] capVal_r [2];
    logic [1:0] extSync_r;
    logic extPrev_r;
    logic [1:0] capSync1_r;
    logic [1:0] capSync2_r;
    logic [1:0] capPrev_r;
    logic [31:0] prdata_r;
    logic wr;
    logic rd;
    logic frozen;
    logic inputTick;
    logic countTick;
    logic overflow;
    logic carWrite;
    logic forceReload;
    logic csrRead;
    logic [1:0] capRead;
    logic [1:0] capEdge;
    logic [6:0] tapMask;
    logic mapped;

    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = paddr <= art_pkg::OFF_CAP2 && paddr[1:0] == 2'b00;
    assign pslverr = psel && penable && !mapped;
    // Control registers hold while halted on the external clock
    assign frozen = haltMode && ctrl_r.extClk;

    // Pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extSync_r <= 2'b00;
            extPrev_r <= 1'b0;
            capSync1_r <= 2'b00;
            capSync2_r <= 2'b00;
            capPrev_r <= 2'b00;
        end else begin
            extSync_r <= {extSync_r[0], externalTimerClock};
            extPrev_r <= extSync_r[1];
            capSync1_r <= captureInPin;
            capSync2_r <= capSync1_r;
            capPrev_r <= capSync2_r;
        end
    end

    // Prescaler input select
    assign inputTick = ctrl_r.extClk ? (extSync_r[1] && !extPrev_r) : 1'b1;
    assign tapMask = 7'(({7'h00, 1'b1} << ctrl_r.preSel) - 8'h01);
    assign countTick = ctrl_r.run && inputTick && ((prescale_r & tapMask) == tapMask);
    assign overflow = countTick && counter_r == art_pkg::CNT_TOP;
    assign carWrite = wr && isAddr(paddr, art_pkg::OFF_CAR) && !frozen;
    assign forceReload = wr && isAddr(paddr, art_pkg::OFF_CSR) && !frozen
        && pwdata[art_pkg::CSR_FORCE];
    assign csrRead = rd && isAddr(paddr, art_pkg::OFF_CSR);
    assign capRead[0] = rd && isAddr(paddr, art_pkg::OFF_CAP1);
    assign capRead[1] = rd && isAddr(paddr, art_pkg::OFF_CAP2);

    // Prescaler
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale_r <= 7'h00;
        end else if (carWrite || forceReload) begin
            prescale_r <= 7'h00;
        end else if (ctrl_r.run && inputTick) begin
            prescale_r <= prescale_r + 7'h01;
        end
    end

    // Counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_r <= art_pkg::RESET_VAL;
        end else if (carWrite) begin
            counter_r <= pwdata[7:0];
        end else if (forceReload) begin
            counter_r <= reload_r;
        end else if (overflow) begin
            counter_r <= reload_r;
        end else if (countTick) begin
            counter_r <= counter_r + 8'h01;
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= '0;
            capCtl_r <= '0;
            reload_r <= art_pkg::RESET_VAL;
            outEnable_r <= 4'h0;
            polarity_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                duty_r[i] <= art_pkg::RESET_VAL;
            end
        end else if (wr && !frozen) begin
            if (isAddr(paddr, art_pkg::OFF_CSR)) begin
                ctrl_r.extClk <= pwdata[art_pkg::CSR_EXTCLK];
                ctrl_r.preSel <= pwdata[art_pkg::CSR_PRE_HI:art_pkg::CSR_PRE_LO];
                ctrl_r.run <= pwdata[art_pkg::CSR_RUN];
                ctrl_r.ovIe <= pwdata[art_pkg::CSR_OVIE];
            end
            if (isAddr(paddr, art_pkg::OFF_RELOAD)) begin
                reload_r <= pwdata[7:0];
            end
            if (isAddr(paddr, art_pkg::OFF_PWMCTL)) begin
                outEnable_r <= pwdata[7:4];
                polarity_r <= pwdata[3:0];
            end
            if (isAddr(paddr, art_pkg::OFF_CAPCSR)) begin
                capCtl_r.edgeRise <= pwdata[art_pkg::CAP_EDGE_LO +: 2];
                capCtl_r.irqEn <= pwdata[art_pkg::CAP_IE_LO +: 2];
            end
            for (int i = 0; i < 4; i++) begin
                if (isAddr(paddr, 8'(art_pkg::OFF_DUTY0 - 8'(4 * i)))) begin
                    duty_r[i] <= pwdata[7:0];
                end
            end
        end
    end

    // Overflow flag, set wins over read clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflowFlag_r <= 1'b0;
        end else if (overflow) begin
            overflowFlag_r <= 1'b1;
        end else if (csrRead) begin
            overflowFlag_r <= 1'b0;
        end
    end

    // Compare shadows and PWM levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwmLevel_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                shadow_r[i] <= art_pkg::RESET_VAL;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (overflow) begin
                    shadow_r[i] <= duty_r[i];
                    pwmLevel_r[i] <= 1'b1;
                end else if (countTick && counter_r + 8'h01 > shadow_r[i]) begin
                    pwmLevel_r[i] <= 1'b0;
                end
            end
        end
    end

    // Polarity applied after the register so a change shows at once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulseOutEnable <= 4'h0;
        end else begin
            pulseOutEnable <= outEnable_r;
        end
    end
    assign pulseOutPin = outEnable_r & (pwmLevel_r ^ polarity_r);

    // Capture channels
    assign capEdge = (capSync2_r & ~capPrev_r & capCtl_r.edgeRise)
        | (~capSync2_r & capPrev_r & ~capCtl_r.edgeRise);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capFlag_r <= 2'b00;
            capVal_r[0] <= art_pkg::RESET_VAL;
            capVal_r[1] <= art_pkg::RESET_VAL;
        end else begin
            for (int c = 0; c < 2; c++) begin
                // A read in the same cycle frees the register, so the new edge is kept
                if (capEdge[c] && (!capFlag_r[c] || capRead[c])) begin
                    capVal_r[c] <= counter_r;
                    capFlag_r[c] <= 1'b1;
                end else if (capRead[c]) begin
                    capFlag_r[c] <= 1'b0;
                end
            end
        end
    end

    assign overflowIrq = overflowFlag_r && ctrl_r.ovIe;
    assign captureIrq = capFlag_r & capCtl_r.irqEn;
    assign wakeUp = haltMode && (overflowIrq || captureIrq != 2'b00);

    // Read data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                art_pkg::OFF_CSR: prdata_r <= {24'h0, ctrl_r.extClk, ctrl_r.preSel,
                    ctrl_r.run, 1'b0, ctrl_r.ovIe, overflowFlag_r};
                art_pkg::OFF_CAR: prdata_r <= {24'h0, counter_r};
                art_pkg::OFF_RELOAD: prdata_r <= {24'h0, reload_r};
                art_pkg::OFF_PWMCTL: prdata_r <= {24'h0, outEnable_r, polarity_r};
                art_pkg::OFF_DUTY0: prdata_r <= {24'h0, duty_r[0]};
                art_pkg::OFF_DUTY1: prdata_r <= {24'h0, duty_r[1]};
                art_pkg::OFF_DUTY2: prdata_r <= {24'h0, duty_r[2]};
                art_pkg::OFF_DUTY3: prdata_r <= {24'h0, duty_r[3]};
                art_pkg::OFF_CAPCSR: prdata_r <= {24'h0, 2'b00, capCtl_r.edgeRise,
                    capCtl_r.irqEn, capFlag_r};
                art_pkg::OFF_CAP1: prdata_r <= {24'h0, capVal_r[0]};
                art_pkg::OFF_CAP2: prdata_r <= {24'h0, capVal_r[1]};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_r;

    a_ovf_irq_level: assert property (@(posedge clk) disable iff (!rstn)
        overflow |=> overflowFlag_r) else $error("overflow flag not set");
    a_reload_on_wrap: assert property (@(posedge clk) disable iff (!rstn)
        overflow && !carWrite && !forceReload |=> counter_r == $past(reload_r))
        else $error("no reload at overflow");
    a_capture_blocked: assert property (@(posedge clk) disable iff (!rstn)
        capFlag_r[0] && !capRead[0] |=> $stable(capVal_r[0]))
        else $error("capture overwritten");
    a_capture_value: assert property (@(posedge clk) disable iff (!rstn)
        capEdge[1] && !capFlag_r[1] |=> capVal_r[1] == $past(counter_r) && capFlag_r[1])
        else $error("capture value wrong");
    a_stop_holds: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl_r.run && !carWrite && !forceReload |=> $stable(counter_r) && $stable(prescale_r))
        else $error("counter moved while stopped");
    a_force_clears: assert property (@(posedge clk) disable iff (!rstn)
        forceReload && !carWrite |=> prescale_r == 7'h00 && counter_r == $past(reload_r))
        else $error("force reload failed");
    a_shadow_stable: assert property (@(posedge clk) disable iff (!rstn)
        !overflow |=> $stable(shadow_r[2])) else $error("shadow changed");
    a_frozen_ctrl: assert property (@(posedge clk) disable iff (!rstn)
        frozen |=> $stable(reload_r) || !$past(frozen)) else $error("frozen write");
    a_cap_irq: assert property (@(posedge clk) disable iff (!rstn)
        captureIrq[0] == (capFlag_r[0] && capCtl_r.irqEn[0]))
        else $error("capture irq mismatch");
    c_overflow: cover property (@(posedge clk) disable iff (!rstn) overflow);
    c_capture: cover property (@(posedge clk) disable iff (!rstn) capEdge[0] && !capFlag_r[0]);
    c_wake: cover property (@(posedge clk) disable iff (!rstn) wakeUp);
endmodule // art_timer
